// [hw/pae_pkg.sv]
`default_nettype none
package pae_pkg;

    // ==========================================================
    // channel count and register map
    localparam int unsigned NCH        = 3;
    localparam logic [11:0] CFG_OFF    = 12'h000;
    localparam logic [11:0] TYPE_OFF   = 12'h004;
    localparam logic [11:0] HYST0_OFF  = 12'h008;
    localparam logic [11:0] HYST1_OFF  = 12'h00c;
    localparam logic [11:0] HYST2_OFF  = 12'h010;
    localparam logic [11:0] STAT_OFF   = 12'h014;
    localparam logic [11:0] IST_OFF    = 12'h018;
    localparam logic [11:0] IMASK_OFF  = 12'h01c;
    localparam logic [11:0] TBL_OFF    = 12'h100;

    // ==========================================================
    // field positions
    localparam int unsigned CFG_ASSIGN_LSB = 0;
    localparam int unsigned CFG_INV_LSB    = 4;
    localparam int unsigned TYPE_STRIDE    = 8;
    localparam int unsigned STAT_LAMP_LSB  = 0;
    localparam int unsigned STAT_ARMED_LSB = 4;

    // ==========================================================
    // reset values
    localparam logic [2:0] ASSIGN_RST = 3'h3;
    localparam logic [2:0] INV_RST    = 3'h0;
    localparam logic [3:0] TYPE_RST   = 4'h2;
    localparam int         HYST_RST_NUM = 2;
    localparam int         HYST_RST_DEN = 10000;

    // ==========================================================
    // alarm type codes
    localparam logic [3:0] T_DEV_BAND    = 4'h1;
    localparam logic [3:0] T_DEV_UP      = 4'h2;
    localparam logic [3:0] T_DEV_LO      = 4'h3;
    localparam logic [3:0] T_DEV_RANGE   = 4'h4;
    localparam logic [3:0] T_DEV_BAND_SB = 4'h5;
    localparam logic [3:0] T_DEV_UP_SB   = 4'h6;
    localparam logic [3:0] T_DEV_LO_SB   = 4'h7;
    localparam logic [3:0] T_ABS_UP      = 4'h8;
    localparam logic [3:0] T_ABS_LO      = 4'h9;
    localparam logic [3:0] T_ABS_UP_SB   = 4'ha;
    localparam logic [3:0] T_ABS_LO_SB   = 4'hb;

    // ==========================================================
    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PAE_UP,
        PAE_LO,
        PAE_OUT,
        PAE_IN
    } pae_shape_e;

endpackage
`default_nettype wire

// [hw/pae_alarm_eval.sv]
// Operation
// - three channels; only a channel assigned to an output operates
// - decision comes from type, alarm value and hysteresis together
// - per-channel type code 1..11, reset to 2, deviation upper limit
// - type 1 with negative alarm value is always on
// - type 4 with negative alarm value is always off
// - deviation types offset from target; types 8..11 compare to value
// - per-channel hysteresis, reset to 0.02 percent of full scale
// - standby holds output off until value leaves then re-enters region
// - standby applies to types 5, 6, 7, 10 and 11 only
// - standby cleared once alarm is output, until re-armed
// - re-arm on run, power-up, pattern, step, advance, target, value, shift
// - contact follows alarm or its complement; lamp follows alarm
// - per-channel contact polarity, reset to normal (close in alarm)
// - alarm values come from the active pattern, one per channel
// - alarm value shares the process value's decimal scaling
`timescale 1ns/10ps
`default_nettype none
module pae_alarm_eval #(
    parameter int unsigned VW              = 16,
    parameter int unsigned NPAT            = 8,
    parameter int          FULL_SCALE_SPAN = 10000
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      ce,
    input  wire logic [11:0]               awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [11:0]               araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic signed [VW-1:0]      measured_process_value,
    input  wire logic signed [VW-1:0]      present_target_value,
    input  wire logic [$clog2(NPAT)-1:0]   pattern_sel,
    input  wire logic                      run_start,
    input  wire logic                      pattern_start,
    input  wire logic                      step_advance,
    input  wire logic                      manual_advance,
    input  wire logic                      target_edit,
    input  wire logic                      shift_edit,
    output logic [2:0]                     contact,
    output logic [2:0]                     lamp,
    output logic                           irq
);
    localparam int unsigned NCH = pae_pkg::NCH;
    localparam int unsigned CW  = VW + 2;
    localparam int unsigned PW  = $clog2(NPAT);
    localparam logic [VW-1:0] HYST_RST = VW'(FULL_SCALE_SPAN * pae_pkg::HYST_RST_NUM
                                             / pae_pkg::HYST_RST_DEN);

    typedef enum logic [3:0] {
        R_CFG, R_TYPE, R_HYST0, R_HYST1, R_HYST2, R_STAT, R_IST, R_IMASK, R_TBL, R_NONE
    } pae_reg_e;

    // ==========================================================
    // state
    logic [NCH-1:0]          cfg_assign, cfg_inv, ist, imask;
    logic [NCH-1:0][3:0]     atype;
    logic [NCH-1:0][VW-1:0]  hyst;
    logic signed [VW-1:0]    tbl [NPAT*4];
    logic                    aw_got, w_got;
    logic [11:0]             awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic [NCH-1:0]          alarm_st, armed, left_rgn, eff, rearm, rise;
    logic [NCH-1:0]          next_cfg_assign, next_cfg_inv, next_ist, next_imask;
    logic [NCH-1:0][3:0]     next_atype;
    logic [NCH-1:0][VW-1:0]  next_hyst;
    logic                    next_aw_got, next_w_got, next_awready, next_wready;
    logic                    next_bvalid, next_arready, next_rvalid, next_irq;
    logic [11:0]             next_awaddr_q;
    logic [31:0]             next_wdata_q, next_rdata, bm, nv;
    logic [3:0]              next_wstrb_q;
    logic [1:0]              next_bresp, next_rresp;
    logic                    do_wr;
    pae_reg_e                wsel, rsel;

    // ==========================================================
    // address decode
    function automatic pae_reg_e dec(input logic [11:0] a);
        if (a == pae_pkg::CFG_OFF) begin
            dec = R_CFG;
        end else if (a == pae_pkg::TYPE_OFF) begin
            dec = R_TYPE;
        end else if (a == pae_pkg::HYST0_OFF) begin
            dec = R_HYST0;
        end else if (a == pae_pkg::HYST1_OFF) begin
            dec = R_HYST1;
        end else if (a == pae_pkg::HYST2_OFF) begin
            dec = R_HYST2;
        end else if (a == pae_pkg::STAT_OFF) begin
            dec = R_STAT;
        end else if (a == pae_pkg::IST_OFF) begin
            dec = R_IST;
        end else if (a == pae_pkg::IMASK_OFF) begin
            dec = R_IMASK;
        end else if (a >= pae_pkg::TBL_OFF && a < pae_pkg::TBL_OFF + 12'(NPAT * 16)
                     && a[3:2] != 2'h3) begin
            dec = R_TBL;
        end else begin
            dec = R_NONE;
        end
    endfunction

    function automatic logic [31:0] rdval(input pae_reg_e s, input logic [11:0] a);
        logic [PW+1:0] ti;
        ti = a[PW+3:2];
        rdval = 32'h0;
        case (s)
            R_CFG: begin
                rdval[pae_pkg::CFG_ASSIGN_LSB +: NCH] = cfg_assign;
                rdval[pae_pkg::CFG_INV_LSB +: NCH] = cfg_inv;
            end
            R_TYPE: begin
                for (int k = 0; k < NCH; k++) begin
                    rdval[k*pae_pkg::TYPE_STRIDE +: 4] = atype[k];
                end
            end
            R_HYST0: rdval[VW-1:0] = hyst[0];
            R_HYST1: rdval[VW-1:0] = hyst[1];
            R_HYST2: rdval[VW-1:0] = hyst[2];
            R_STAT: begin
                rdval[pae_pkg::STAT_LAMP_LSB +: NCH] = lamp;
                rdval[pae_pkg::STAT_ARMED_LSB +: NCH] = armed;
            end
            R_IST: rdval[NCH-1:0] = ist;
            R_IMASK: rdval[NCH-1:0] = imask;
            R_TBL: rdval[VW-1:0] = tbl[ti];
            default: rdval = 32'h0;
        endcase
    endfunction

    // ==========================================================
    // bus slave and registers
    always_comb begin
        wsel = dec(awaddr_q);
        rsel = dec(araddr);
        do_wr = aw_got && w_got && !bvalid;
        for (int k = 0; k < 4; k++) begin
            bm[k*8 +: 8] = {8{wstrb_q[k]}};
        end
        nv = (rdval(wsel, awaddr_q) & ~bm) | (wdata_q & bm);
        next_cfg_assign = cfg_assign;
        next_cfg_inv = cfg_inv;
        next_atype = atype;
        next_hyst = hyst;
        next_imask = imask;
        next_ist = ist;
        next_aw_got = aw_got || (awvalid && awready);
        next_w_got = w_got || (wvalid && wready);
        next_awaddr_q = (awvalid && awready) ? awaddr : awaddr_q;
        next_wdata_q = (wvalid && wready) ? wdata : wdata_q;
        next_wstrb_q = (wvalid && wready) ? wstrb : wstrb_q;
        next_bvalid = bvalid && !bready;
        next_bresp = bresp;
        if (do_wr) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wsel == R_NONE) ? pae_pkg::RESP_SLVERR : pae_pkg::RESP_OKAY;
            case (wsel)
                R_CFG: begin
                    next_cfg_assign = nv[pae_pkg::CFG_ASSIGN_LSB +: NCH];
                    next_cfg_inv = nv[pae_pkg::CFG_INV_LSB +: NCH];
                end
                R_TYPE: begin
                    for (int k = 0; k < NCH; k++) begin
                        next_atype[k] = nv[k*pae_pkg::TYPE_STRIDE +: 4];
                    end
                end
                R_HYST0: next_hyst[0] = nv[VW-1:0];
                R_HYST1: next_hyst[1] = nv[VW-1:0];
                R_HYST2: next_hyst[2] = nv[VW-1:0];
                R_IMASK: next_imask = nv[NCH-1:0];
                R_IST: next_ist = ist & ~(wdata_q[NCH-1:0] & bm[NCH-1:0]);
                default: next_ist = ist;
            endcase
        end
        next_ist = next_ist | rise;
        next_irq = |(next_ist & next_imask);
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;
        next_rvalid = rvalid && !rready;
        next_rdata = rdata;
        next_rresp = rresp;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = rdval(rsel, araddr);
            next_rresp = (rsel == R_NONE) ? pae_pkg::RESP_SLVERR : pae_pkg::RESP_OKAY;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_assign <= pae_pkg::ASSIGN_RST;
            cfg_inv <= pae_pkg::INV_RST;
            atype <= {NCH{pae_pkg::TYPE_RST}};
            hyst <= {NCH{HYST_RST}};
            imask <= '0;
            ist <= '0;
            irq <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= pae_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= pae_pkg::RESP_OKAY;
        end else if (ce) begin
            cfg_assign <= next_cfg_assign;
            cfg_inv <= next_cfg_inv;
            atype <= next_atype;
            hyst <= next_hyst;
            imask <= next_imask;
            ist <= next_ist;
            irq <= next_irq;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ==========================================================
    // per-pattern alarm value table
    always_ff @(posedge aclk) begin
        // alarm values default to zero
        if (!aresetn) begin
            tbl <= '{default: '0};
        end else if (ce && do_wr && wsel == R_TBL) begin
            tbl[awaddr_q[PW+3:2]] <= nv[VW-1:0];
        end
    end

    // ==========================================================
    // alarm channels
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic signed [CW-1:0] meas, x, hi, lo, h;
        logic signed [VW-1:0] xprev, next_xprev;
        logic                 set_c, clr_c, sb, ok, alm, arm, lft, lmp, cnt;
        logic                 next_alm, next_arm, next_lft, next_lmp, next_cnt;
        pae_pkg::pae_shape_e  shp;
        always_comb begin
            meas = CW'(measured_process_value);
            x = CW'(tbl[{pattern_sel, 2'(i)}]);
            h = CW'({1'b0, hyst[i]});
            ok = atype[i] >= pae_pkg::T_DEV_BAND && atype[i] <= pae_pkg::T_ABS_LO_SB;
            sb = atype[i] inside {pae_pkg::T_DEV_BAND_SB, pae_pkg::T_DEV_UP_SB,
                                  pae_pkg::T_DEV_LO_SB, pae_pkg::T_ABS_UP_SB,
                                  pae_pkg::T_ABS_LO_SB};
            if (atype[i] >= pae_pkg::T_ABS_UP) begin
                hi = x;
                lo = x;
            end else begin
                hi = CW'(present_target_value) + x;
                lo = CW'(present_target_value) - x;
            end
            case (atype[i])
                pae_pkg::T_DEV_BAND, pae_pkg::T_DEV_BAND_SB: shp = pae_pkg::PAE_OUT;
                pae_pkg::T_DEV_RANGE: shp = pae_pkg::PAE_IN;
                pae_pkg::T_DEV_UP, pae_pkg::T_DEV_UP_SB: shp = pae_pkg::PAE_UP;
                pae_pkg::T_ABS_UP, pae_pkg::T_ABS_UP_SB: shp = pae_pkg::PAE_UP;
                default: shp = pae_pkg::PAE_LO;
            endcase
            // same engineering units on both sides
            case (shp)
                // upper and lower limits with hysteresis
                pae_pkg::PAE_UP: begin
                    set_c = meas > hi;
                    clr_c = meas < hi - h;
                end
                pae_pkg::PAE_LO: begin
                    set_c = meas < lo;
                    clr_c = meas > lo + h;
                end
                pae_pkg::PAE_OUT: begin
                    set_c = meas > hi || meas < lo;
                    clr_c = meas < hi - h && meas > lo + h;
                end
                default: begin
                    set_c = meas < hi && meas > lo;
                    clr_c = meas > hi + h || meas < lo - h;
                end
            endcase
            if (atype[i] == pae_pkg::T_DEV_BAND && x < 0) begin
                set_c = 1'b1;
                clr_c = 1'b0;
            end
            if ((atype[i] == pae_pkg::T_DEV_RANGE || atype[i] == pae_pkg::T_DEV_BAND_SB)
                && x < 0) begin
                set_c = 1'b0;
                clr_c = 1'b1;
            end
            next_alm = (set_c || (alm && !clr_c)) && ok && cfg_assign[i];
            rearm[i] = run_start || pattern_start || step_advance || manual_advance
                       || target_edit || shift_edit || x[VW-1:0] != xprev;
            // suppressed until region left and re-entered
            eff[i] = alm && (!sb || !arm || lft);
            next_arm = arm;
            next_lft = lft;
            if (cfg_assign[i]) begin
                if (rearm[i]) begin
                    next_arm = 1'b1;
                    next_lft = 1'b0;
                end else begin
                    if (!alm) begin
                        next_lft = 1'b1;
                    end
                    if (eff[i]) begin
                        next_arm = 1'b0;
                    end
                end
            end
            next_lmp = cfg_assign[i] && eff[i];
            next_cnt = cfg_assign[i] && (eff[i] ^ cfg_inv[i]);
            next_xprev = x[VW-1:0];
            rise[i] = next_lmp && !lmp;
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                alm <= 1'b0;
                arm <= 1'b1;
                lft <= 1'b0;
                lmp <= 1'b0;
                cnt <= 1'b0;
                xprev <= '0;
            end else if (ce) begin
                alm <= next_alm;
                arm <= next_arm;
                lft <= next_lft;
                lmp <= next_lmp;
                cnt <= next_cnt;
                xprev <= next_xprev;
            end
        end
        assign alarm_st[i] = alm;
        assign armed[i] = arm;
        assign left_rgn[i] = lft;
        assign lamp[i] = lmp;
        assign contact[i] = cnt;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    unassigned_off_a: assert property (
        ce |=> ((lamp | contact) & ~$past(cfg_assign)) == '0)
        else $error("unassigned channel drives its contact");
    polarity_map_a: assert property (
        ce |=> contact == ((lamp ^ $past(cfg_inv)) & $past(cfg_assign)))
        else $error("contact does not match lamp and polarity");
    neg_force_on_a: assert property (
        ce && cfg_assign[0] && atype[0] == pae_pkg::T_DEV_BAND && g_ch[0].x < 0
        |=> alarm_st[0])
        else $error("type 1 negative value not forced on");
    neg_force_off_a: assert property (
        ce && atype[0] == pae_pkg::T_DEV_RANGE && g_ch[0].x < 0 |=> !alarm_st[0])
        else $error("type 4 negative value not forced off");
    upper_set_a: assert property (
        ce && cfg_assign[0] && atype[0] == pae_pkg::T_DEV_UP
        && g_ch[0].meas > g_ch[0].hi |=> alarm_st[0])
        else $error("upper limit exceeded without alarm");
    hyst_hold_a: assert property (
        ce && cfg_assign[0] && alarm_st[0] && atype[0] == pae_pkg::T_DEV_UP
        && g_ch[0].meas >= g_ch[0].hi - g_ch[0].h |=> alarm_st[0])
        else $error("alarm released inside hysteresis");
    standby_hold_a: assert property (
        ce && g_ch[0].sb && armed[0] && !left_rgn[0] |=> !lamp[0])
        else $error("standby did not suppress output");
    standby_clear_a: assert property (
        ce && cfg_assign[0] && eff[0] && !rearm[0] |=> !armed[0])
        else $error("standby not cleared by alarm output");
    rearm_run_a: assert property (
        ce && cfg_assign[0] && run_start |=> armed[0] && !left_rgn[0])
        else $error("run start did not re-arm standby");
    irq_level_a: assert property (
        ce |=> irq == |(ist & imask))
        else $error("interrupt level mismatch");
    write_resp_a: assert property (
        ce && aw_got && w_got && !bvalid |=> bvalid)
        else $error("write response missing");

    standby_seen_c: cover property (g_ch[0].sb && armed[0] && left_rgn[0] && alarm_st[0]);
    inverted_c: cover property (cfg_inv[0] && contact[0] == 1'b0 && lamp[0]);
    irq_c: cover property (irq);
    band_c: cover property (atype[1] == pae_pkg::T_DEV_BAND && alarm_st[1]);

endmodule
`default_nettype wire

// [sim/pae_process_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// process measurement source
module pae_process_model (
    input  wire logic               aclk,
    input  wire logic signed [15:0] want_meas,
    input  wire logic signed [15:0] want_tgt,
    output logic signed [15:0]      measured_process_value,
    output logic signed [15:0]      present_target_value
);
    always_ff @(posedge aclk) begin
        measured_process_value <= want_meas;
        present_target_value   <= want_tgt;
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// alarm evaluator bench
module testbench;
    logic               aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata, rd;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, rr, br;
    logic [2:0]         psel, contact, lamp;
    logic [5:0]         ev;
    logic signed [15:0] meas, tgt, mpv, tsp;
    int                 bad_count = 0, n_compared = 0, cyc = 0, t, x, s, p, k, inv;
    int                 tp[6] = '{1, 2, 3, 4, 8, 9};
    int                 sbt[4] = '{5, 7, 10, 11}, sbin[4] = '{200, -200, 200, 0};
    int                 sbout[4] = '{0, 0, 0, 200};
    pae_process_model i_pae_process_model (.aclk(aclk), .want_meas(meas), .want_tgt(tgt),
        .measured_process_value(mpv), .present_target_value(tsp));
    pae_alarm_eval i_pae_alarm_eval (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .measured_process_value(mpv), .present_target_value(tsp), .pattern_sel(psel),
        .run_start(ev[0]), .pattern_start(ev[1]), .step_advance(ev[2]),
        .manual_advance(ev[3]), .target_edit(ev[4]), .shift_edit(ev[5]),
        .contact(contact), .lamp(lamp), .irq(irq));
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        br = bresp;
    endtask
    task automatic rdr(logic [11:0] a);
        araddr <= a; arvalid <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata; rr = rresp;
    endtask
    function automatic logic f(int t, int x, int s, int p);
        case (t)
            1: return x < 0 || p > s + x || p < s - x;
            2: return p > s + x;
            3: return p < s - x;
            4: return x >= 0 && p > s - x && p < s + x;
            8: return p > x;
            default: return p < x;
        endcase
    endfunction
    function automatic bit near(int a, int b);
        return a - b < 5 && b - a < 5;
    endfunction
    initial begin
        aresetn = 0; awvalid = 0; wvalid = 0; bready = 1; arvalid = 0; rready = 1; ce = 1;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; psel = 0; ev = 0; meas = 0; tgt = 0;
        void'($urandom(6401));
        tick(20);
        aresetn <= 1;
        tick(1);
        rdr(12'h004); chk("type", 32'h00020202, rd);
        rdr(12'h000); chk("cfg", 32'h3, rd);
        rdr(12'h10c); chk("unmapped", 32'h2, {30'h0, rr});
        wr(12'h10c, 32'h0); chk("wresp", 32'h2, {30'h0, br});
        for (int i = 0; i < 40; i++) begin
            t = tp[$urandom % 6]; x = $urandom_range(200) - 100; k = $urandom % 8;
            s = $urandom_range(2000) - 1000; p = $urandom_range(4000) - 2000; inv = $urandom % 2;
            while (near(p, s + x) || near(p, s - x) || near(p, x)) p += 11;
            wr(12'h004, 32'h00020200 | t); wr(12'h000, 32'h3 | inv << 4);
            wr(12'(256 + k * 16), 32'(x));
            psel <= 3'(k); meas <= 16'(p); tgt <= 16'(s);
            tick(6);
            chk("lamp0", f(t, x, s, p), lamp[0]);
            chk("contact0", f(t, x, s, p) ^ inv[0], contact[0]);
            chk("contact2", 0, contact[2]);
        end
        wr(12'h004, 32'h00020202); wr(12'h000, 32'h3); wr(12'h100, 32'd100);
        psel <= 0; tgt <= 0;
        for (int i = 0; i < 3; i++) begin
            meas <= 16'(101 - 2 * i); tick(6);
            chk("hysteresis", i < 2, lamp[0]);
        end
        wr(12'h004, 32'h00020206); meas <= 200; tick(6);
        ev <= 6'(1 << ($urandom % 6)); tick(1); ev <= 0; tick(6);
        chk("standby", 0, lamp[0]);
        wr(12'h018, 32'h7); wr(12'h01c, 32'h1); meas <= 0; tick(6); meas <= 200; tick(6);
        chk("rearmed", 1, lamp[0]);
        chk("irq", 1, irq);
        wr(12'h01c, 32'h0); tick(2); chk("masked", 0, irq);
        wr(12'h01c, 32'h1); tick(2); chk("unmasked", 1, irq);
        wr(12'h018, 32'h1); tick(2); chk("cleared", 0, irq);
        for (int i = 0; i < 4; i++) begin
            wr(12'h004, 32'h00020200 | sbt[i]); meas <= 16'(sbin[i]); tick(6);
            ev <= 6'(1 << ($urandom % 6)); tick(1); ev <= 0; tick(6);
            chk("standby_in", 0, lamp[0]);
            meas <= 16'(sbout[i]); tick(6); meas <= 16'(sbin[i]); tick(6);
            chk("standby_re", 1, lamp[0]);
        end
        ce <= 0; meas <= 200; tick(6);
        chk("frozen", 1, lamp[0]);
        ce <= 1; tick(6);
        chk("thawed", 0, lamp[0]);
        conclude();
    end
endmodule
`default_nettype wire
